// [verilog/drs_route_selector.sv]
// DDC route selector: switch debounce, input enables, termination select,
// DDC line bridging both ways between two sources and four displays, collision LEDs.
// Assumes raw switch and DDC pin levels, open-drain pads outside.
`timescale 1ns/1ps
`default_nettype none

module drs_route_selector import drs_pkg::*; #(
	parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Configuration switches, raw
	input wire logic [7:0] input_config_switch_bank,
	// Source side DDC lines
	input wire drs_ddc_type [1:0] src_ddc_in,
	output drs_ddc_type [1:0] src_ddc_out,
	output drs_ddc_type [1:0] src_ddc_oe_n,
	// Display side DDC lines
	input wire drs_ddc_type [3:0] dsp_ddc_in,
	output drs_ddc_type [3:0] dsp_ddc_out,
	output drs_ddc_type [3:0] dsp_ddc_oe_n,
	// Port control
	output logic input0_power_enable,
	output logic input1_power_enable,
	output logic back_termination_enable,
	// Indicators
	output logic led_green,
	output logic led_red
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [7:0] sw_s1;
		logic [7:0] sw_s2;
		logic [7:0] sw_last;
		logic [7:0] sw_stable;
		logic [15:0] deb_cnt;
		logic [3:0] src_s1;
		logic [3:0] src_s2;
		logic [7:0] dsp_s1;
		logic [7:0] dsp_s2;
		drs_brg_type [3:0] brg;
		logic [3:0][2:0] settle;
		logic [3:0] src_oe_n;
		logic [7:0] dsp_oe_n;
		logic in0_pwr;
		logic in1_pwr;
		logic term;
		logic green;
		logic red;
	} drs_state_type;

	drs_state_type st;
	drs_state_type next_st;

	localparam logic [15:0] DEB_LAST = 16'(DEBOUNCE_CYCLES - 1);

	// Route of an input port from a switch image
	function automatic logic [1:0] route_of(input logic [7:0] sw, input int port);
		route_of = (port == 0) ? {sw[SW_IN0_ROUTE_MSB], sw[SW_IN0_ROUTE_LSB]}
			: {sw[SW_IN1_ROUTE_MSB], sw[SW_IN1_ROUTE_LSB]};
	endfunction

	logic [1:0] route0;
	logic [1:0] route1;
	logic collide;
	assign route0 = route_of(st.sw_stable, 0);
	assign route1 = route_of(st.sw_stable, 1);
	assign collide = (route0 == route1);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic [1:0] rt;
		logic act;
		logic src_low;
		logic dsp_low;
		logic [2:0] tgt;
		rt = 2'h0;
		act = 1'b0;
		src_low = 1'b0;
		dsp_low = 1'b0;
		tgt = 3'h0;
		next_st = st;

		// Two-stage synchronisers; stage one feeds stage two only
		next_st.sw_s1 = input_config_switch_bank; // RQ11
		next_st.sw_s2 = st.sw_s1;
		next_st.src_s1 = src_ddc_in;
		next_st.src_s2 = st.src_s1;
		next_st.dsp_s1 = dsp_ddc_in;
		next_st.dsp_s2 = st.dsp_s1;

		// Debounce: the bank must hold still for the whole window
		next_st.sw_last = st.sw_s2;
		if (st.sw_s2 != st.sw_last) begin
			next_st.deb_cnt = 16'h0000;
		end else if (st.deb_cnt == DEB_LAST) begin
			next_st.sw_stable = st.sw_s2; // RQ11
		end else begin
			next_st.deb_cnt = st.deb_cnt + 16'h0001;
		end

		next_st.in0_pwr = st.sw_stable[SW_IN0_POWER]; // RQ1
		next_st.in1_pwr = st.sw_stable[SW_IN1_POWER]; // RQ2
		next_st.term = !st.sw_stable[SW_NO_TERM]; // RQ3
		next_st.red = collide; // RQ10
		next_st.green = !collide; // RQ9

		// Line bridges; bridge b is port b/2, line b%2 (1 = clock)
		next_st.dsp_oe_n = 8'hff;
		for (int b = 0; b < NUM_BRG; b++) begin
			rt = (b < 2) ? route0 : route1; // RQ5 RQ6
			act = ((b < 2) ? st.sw_stable[SW_IN0_POWER] : st.sw_stable[SW_IN1_POWER])
				&& !collide;
			tgt = {rt, 1'(b % 2)};
			src_low = !st.src_s2[b];
			dsp_low = !st.dsp_s2[tgt];
			unique case (st.brg[b])
				BRG_IDLE: begin
					if (act && src_low) begin
						next_st.brg[b] = BRG_SRC;
					end else if (act && dsp_low) begin
						next_st.brg[b] = BRG_DSP;
					end
				end
				BRG_SRC: begin
					if (!src_low || !act) begin
						next_st.brg[b] = BRG_SETTLE;
						next_st.settle[b] = SETTLE_CYC;
					end
				end
				BRG_DSP: begin
					if (!dsp_low || !act) begin
						next_st.brg[b] = BRG_SETTLE;
						next_st.settle[b] = SETTLE_CYC;
					end
				end
				BRG_SETTLE: begin
					// Our own released low still echoes through the synchroniser
					if (st.settle[b] == 3'h0) begin
						next_st.brg[b] = BRG_IDLE;
					end else begin
						next_st.settle[b] = st.settle[b] - 3'h1;
					end
				end
			endcase
			next_st.src_oe_n[b] = (next_st.brg[b] != BRG_DSP); // RQ7
			if (next_st.brg[b] == BRG_SRC) begin
				next_st.dsp_oe_n[tgt] = 1'b0; // RQ7
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st <= '{sw_s1: SW_RESET, sw_s2: SW_RESET, sw_last: SW_RESET,
				sw_stable: SW_RESET, deb_cnt: 16'h0000, src_s1: 4'hf, src_s2: 4'hf,
				dsp_s1: 8'hff, dsp_s2: 8'hff, brg: '{4{BRG_IDLE}}, settle: 12'h000,
				src_oe_n: 4'hf, dsp_oe_n: 8'hff, in0_pwr: 1'b0, in1_pwr: 1'b0,
				term: 1'b0, green: 1'b0, red: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Open-drain: the pad value is always low, only the enable moves
	assign src_ddc_out = '0;
	assign dsp_ddc_out = '0;
	assign src_ddc_oe_n = st.src_oe_n;
	assign dsp_ddc_oe_n = st.dsp_oe_n;
	assign input0_power_enable = st.in0_pwr;
	assign input1_power_enable = st.in1_pwr;
	assign back_termination_enable = st.term;
	assign led_green = st.green;
	assign led_red = st.red;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	chk_in0_power_follow: assert property ( // RQ1
		$changed(st.sw_stable[SW_IN0_POWER]) |=> input0_power_enable == st.sw_stable[SW_IN0_POWER]
	) else $error("input 0 enable does not follow its switch");

	chk_in1_power_follow: assert property ( // RQ2
		##1 input1_power_enable == $past(st.sw_stable[SW_IN1_POWER])
	) else $error("input 1 enable does not follow its switch");

	chk_term_inverse: assert property ( // RQ3
		st.sw_stable[SW_NO_TERM] |=> !back_termination_enable
	) else $error("termination on while its switch is on");

	chk_in0_route_target: assert property ( // RQ5
		(st.brg[1] == BRG_SRC) && $stable(st.sw_stable)
			|-> !dsp_ddc_oe_n[{st.sw_stable[SW_IN0_ROUTE_MSB], st.sw_stable[SW_IN0_ROUTE_LSB]}].scl
	) else $error("input 0 clock not driven onto its routed output");

	chk_in1_route_target: assert property ( // RQ6
		(st.brg[3] == BRG_SRC) && $stable(st.sw_stable)
			|-> !dsp_ddc_oe_n[{st.sw_stable[SW_IN1_ROUTE_MSB], st.sw_stable[SW_IN1_ROUTE_LSB]}].scl
	) else $error("input 1 clock not driven onto its routed output");

	chk_dsp_low_src: assert property ( // RQ7
		(st.brg[0] == BRG_IDLE) && input0_power_enable && led_green && $stable(st.sw_stable)
			&& st.src_s2[0] && !st.dsp_s2[{route0, 1'b0}]
			|=> !src_ddc_oe_n[0].sda
	) else $error("display low not passed to source 0 data");

	chk_green_distinct: assert property ( // RQ9
		(route0 != route1) |=> led_green
	) else $error("green LED dark with distinct routes");

	chk_red_same: assert property ( // RQ10
		(route0 == route1) ##1 (route0 == route1) |=> led_red
	) else $error("red LED dark with a collision");

	chk_leds_exclusive: assert property ( // RQ11
		!(led_green && led_red)
	) else $error("both LEDs lit");

	chk_debounce_hold: assert property ( // RQ11
		$changed(st.sw_stable) |-> $past(st.deb_cnt) == DEB_LAST && $past(st.sw_s2) == st.sw_stable
	) else $error("switch image taken before debounce expired");

endmodule

`default_nettype wire

// [common/drs_pkg.sv]
// Constants and types of the DDC route selector.
// Assumes a 40 MHz system clock and an active-low synchronous reset.
// Notes on behaviour
// RQ1: Input port 0 is active while its power enable switch is on and idle while it is off.
// RQ2: Input port 1 is active while its power enable switch is on and idle while it is off.
// RQ3: Back termination is applied while the third switch is off and removed while it is on.
// RQ4: The operator leaves the termination switch off, as shipped, unless told otherwise.
// RQ5: Switches 5 and 6, low bit first, pick the output whose DDC channel serves input 0.
// RQ6: Switches 7 and 8, low bit first, pick the output whose DDC channel serves input 1.
// RQ7: The DDC lines of the chosen output are bridged through to the source on that input.
// RQ8: The operator never routes both inputs to the DDC channel of one output.
// RQ9: The green LED is lit while the two DDC selections name different outputs.
// RQ10: The red LED is lit while both DDC selections name the same output.
// RQ11: Switches are synchronised and debounced before use, and both LEDs are never lit together.
`default_nettype none

package drs_pkg;

	// ****************************************************************
	// Switch bank layout (bit n-1 is switch n, 1 means on)
	// ****************************************************************
	localparam int SW_WIDTH = 8;
	localparam int SW_IN0_POWER = 0;
	localparam int SW_IN1_POWER = 1;
	localparam int SW_NO_TERM = 2;
	localparam int SW_IN0_ROUTE_LSB = 4;
	localparam int SW_IN0_ROUTE_MSB = 5;
	localparam int SW_IN1_ROUTE_LSB = 6;
	localparam int SW_IN1_ROUTE_MSB = 7;
	localparam logic [7:0] SW_RESET = 8'h00;

	// ****************************************************************
	// Port counts
	// ****************************************************************
	localparam int NUM_IN = 2;
	localparam int NUM_OUT = 4;
	localparam int NUM_BRG = 4;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 25;
	localparam int DEBOUNCE_TIME_US = 1000;
	localparam int DEBOUNCE_CYC = (DEBOUNCE_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int SETTLE_TIME_NS = 100;
	localparam logic [2:0] SETTLE_CYC = 3'((SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ****************************************************************
	// Types
	// ****************************************************************
	// One DDC line pair; the clock line sits in the upper bit
	typedef struct packed {
		logic scl;
		logic sda;
	} drs_ddc_type;

	// Owner of one bridged line
	typedef enum logic [1:0] {
		BRG_IDLE = 2'h0,
		BRG_SRC = 2'h1,
		BRG_SETTLE = 2'h3,
		BRG_DSP = 2'h2
	} drs_brg_type;

endpackage

`default_nettype wire

// [dv/drs_ddc_far.sv]
// Far side of the DDC wires: sources and displays on pulled-up lines.
// Assumes the bench asks for lows through the pull inputs.
`timescale 1ns/1ps
`default_nettype none

module drs_ddc_far import drs_pkg::*; (
	// Device drive
	input wire drs_ddc_type [1:0] src_oe_n,
	input wire drs_ddc_type [3:0] dsp_oe_n,
	// Far-side pulls, 1 pulls low
	input wire logic [3:0] src_pull,
	input wire logic [7:0] dsp_pull,
	// Wire levels
	output drs_ddc_type [1:0] src_lvl,
	output drs_ddc_type [3:0] dsp_lvl
);
	// Pull-ups, so a released line reads high
	assign src_lvl = src_oe_n & ~src_pull;
	assign dsp_lvl = dsp_oe_n & ~dsp_pull;
endmodule

`default_nettype wire

// [dv/test_drs_route_selector.sv]
// Self-checking bench of the DDC route selector.
// Assumes the far-side model drs_ddc_far and a short debounce.
`timescale 1ns/1ps
`default_nettype none

module test_drs_route_selector import drs_pkg::*; ;
	// ****
	// Signals
	// ****
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] bank = SW_RESET;
	logic [3:0] src_pull = '0;
	logic [7:0] dsp_pull = '0;
	drs_ddc_type [1:0] src_lvl, src_oe_n, src_out;
	drs_ddc_type [3:0] dsp_lvl, dsp_oe_n, dsp_out;
	logic en0, en1, term, green, red;
	int n_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	// Bank, then en0 en1 term green red
	logic [12:0] rows [6] = '{{8'h00, 5'b00101}, {8'h13, 5'b11110}, {8'h07, 5'b11001},
		{8'hf3, 5'b11101}, {8'h21, 5'b10110}, {8'hb2, 5'b01110}};

	always #12.5 clk_sys = ~clk_sys;

	drs_route_selector #(.DEBOUNCE_CYCLES(8)) u_drs_route_selector (
		.clk_sys(clk_sys), .reset_n(reset_n), .input_config_switch_bank(bank),
		.src_ddc_in(src_lvl), .src_ddc_out(src_out), .src_ddc_oe_n(src_oe_n),
		.dsp_ddc_in(dsp_lvl), .dsp_ddc_out(dsp_out), .dsp_ddc_oe_n(dsp_oe_n),
		.input0_power_enable(en0), .input1_power_enable(en1),
		.back_termination_enable(term), .led_green(green), .led_red(red));

	drs_ddc_far u_drs_ddc_far (.src_oe_n(src_oe_n), .dsp_oe_n(dsp_oe_n),
		.src_pull(src_pull), .dsp_pull(dsp_pull), .src_lvl(src_lvl), .dsp_lvl(dsp_lvl));

	// ****
	// Tasks
	// ****
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic outs(input logic [4:0] exp);
		chk("outputs", {3'h0, en0, en1, term, green, red}, {3'h0, exp});
	endtask

	// Waits well past sync plus debounce
	task automatic set_bank(input logic [7:0] v);
		@(negedge clk_sys);
		bank = v;
		repeat (20) @(negedge clk_sys);
	endtask

	// Source i clocks low, then display r drives data low
	task automatic ddc(input int i, input int r, input logic on);
		@(negedge clk_sys);
		src_pull = 4'h2 << (2 * i);
		repeat (6) @(negedge clk_sys);
		chk("dsp_oe_n", dsp_oe_n, on ? ~(8'h02 << (2 * r)) : 8'hff);
		chk("dsp_ddc_out", dsp_out, 8'h00);
		src_pull = '0;
		repeat (12) @(negedge clk_sys);
		dsp_pull = 8'h01 << (2 * r);
		repeat (6) @(negedge clk_sys);
		chk("src_oe_n", {4'h0, src_oe_n}, on ? {4'h0, ~(4'h1 << (2 * i))} : 8'h0f);
		chk("src_ddc_out", {4'h0, src_out}, 8'h00);
		dsp_pull = '0;
		repeat (12) @(negedge clk_sys);
	endtask

	task automatic end_sim();
		$display("Checks done %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ****
	// Sequence
	// ****
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			end_sim();
		end
	end

	initial begin
		repeat (8) @(negedge clk_sys);
		reset_n = 1'b1;
		foreach (rows[k]) begin
			set_bank(rows[k][12:5]);
			outs(rows[k][4:0]);
		end
		for (int r = 0; r < 4; r++) begin
			set_bank({2'((r + 1) % 4), 2'(r), 4'h3});
			ddc(0, r, 1'b1);
			ddc(1, (r + 1) % 4, 1'b1);
		end
		// Both inputs on output 1 breaks the operator rule on purpose
		set_bank(8'h53);
		outs(5'b11101);
		ddc(0, 1, 1'b0);
		// Input 0 off, so its bridge stays released
		set_bank(8'h12);
		ddc(0, 1, 1'b0);
		// Short glitch is ignored, a stable change is taken
		bank = 8'h13;
		repeat (4) @(negedge clk_sys);
		bank = 8'h12;
		repeat (20) @(negedge clk_sys);
		outs(5'b01110);
		set_bank(8'h13);
		outs(5'b11110);
		// Reset in mid-run clears the switch image
		reset_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		outs(5'b00000);
		chk("dsp_oe_n", dsp_oe_n, 8'hff);
		reset_n = 1'b1;
		repeat (3) @(negedge clk_sys);
		outs(5'b00101);
		end_sim();
	end
endmodule

`default_nettype wire
